// ==== rtl/diag_seq.sv ====
// Four-channel speaker load diagnostic sequencer.
// Assumes analog comparators deliver synchronous per-channel fault levels, and that
// the bus front end gives instruction bits as levels and a one-cycle read pulse.
`default_nettype none
module diag_seq #(
  parameter int TICK_CYC = diag_seq_pkg::TICK_CYC,
  parameter int ACQ_TICKS = diag_seq_pkg::ACQ_MS,
  parameter int CYCLE_TICKS = diag_seq_pkg::CYCLE_MS,
  parameter int MUTE_CYC = diag_seq_pkg::FAST_MUTE_CYC
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic diag_enable,
  input wire logic offset_enable,
  input wire logic [1:0] gain_16db,
  input wire logic standby_off,
  input wire logic line_driver_diag,
  input wire logic current_detect_enable,
  input wire logic fast_mute,
  input wire logic host_read,
  input wire logic [3:0] gnd_pos,
  input wire logic [3:0] gnd_neg,
  input wire logic [3:0] short_vs,
  input wire logic [3:0] short_load,
  input wire logic [3:0] open_load,
  input wire logic [3:0] overload,
  input wire logic [3:0] offset_high,
  input wire logic [3:0] peak_500ma,
  output logic [3:0] channel_on,
  output logic outputs_hiz,
  output logic test_pulse,
  output logic line_thresholds,
  output logic [7:0] diagnostic_byte_one,
  output logic [7:0] diag_byte_lr,
  output logic [7:0] diag_byte_rf,
  output logic [7:0] diag_byte_rr,
  output logic offset_active,
  output logic mute_fast_done
);
  typedef logic [5:0] res_t;
  localparam int TW = $clog2(TICK_CYC + 1);
  localparam int AW = $clog2((ACQ_TICKS > CYCLE_TICKS ? ACQ_TICKS : CYCLE_TICKS) + 2);
  localparam logic [AW-1:0] ACQ_END = AW'(ACQ_TICKS - 1);
  localparam logic [AW-1:0] CYC_END = AW'(CYCLE_TICKS - 1);
  localparam logic [2:0] PEAKS_MIN = 3'(diag_seq_pkg::MIN_PEAKS);
  localparam int MW = $clog2(MUTE_CYC + 1);

  // Priority encode of simultaneous faults, open load only when allowed
  function automatic res_t prio(input logic gso, input logic gsk, input logic vs, input logic sl,
                                input logic ol, input logic allow_open);
    res_t r;
    r = '0;
    if (gso) begin
      r[diag_seq_pkg::B_GND] = 1'b1;
      r[diag_seq_pkg::B_VS] = vs;
    end else if (vs) begin
      r[diag_seq_pkg::B_VS] = 1'b1;
    end else if (ol && allow_open) begin
      r[diag_seq_pkg::B_OPEN_OFS] = 1'b1;
    end else if (gsk) begin
      r[diag_seq_pkg::B_GND] = 1'b1;
    end else if (sl) begin
      r[diag_seq_pkg::B_SHORT] = 1'b1;
    end
    return r;
  endfunction

  // Shared 1 ms timebase
  logic [TW-1:0] tick_cnt_reg;
  logic tick;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      tick_cnt_reg <= '0;
    end else if (tick_cnt_reg == TW'(TICK_CYC - 1)) begin
      tick_cnt_reg <= '0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
    end
  end
  assign tick = (tick_cnt_reg == TW'(TICK_CYC - 1));

  logic standby_off_d_reg;
  logic ldr;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      standby_off_d_reg <= 1'b0;
      line_thresholds <= 1'b0;
    end else begin
      standby_off_d_reg <= standby_off;
      line_thresholds <= ldr;
    end
  end
  // Both gain stages must be at 16 dB for the line-driver load limits
  assign ldr = (&gain_16db) && line_driver_diag;
  wire standby_exit = standby_off && !standby_off_d_reg;

  // Any ongoing pulse keeps the power stage off
  logic [3:0] in_pulse;
  logic [3:0] done_flag;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      outputs_hiz <= 1'b1;
      test_pulse <= 1'b0;
    end else begin
      test_pulse <= |in_pulse;
      // Pulse start edge too, else the stage would bias for one cycle before the pulse
      outputs_hiz <= (|in_pulse) || !standby_off || (standby_exit && diag_enable);
    end
  end

  logic [5:0] res_pack [diag_seq_pkg::NCH];
  logic [3:0] perm_v, tweet_v, ofs_v;

  genvar c;
  generate
    for (c = 0; c < diag_seq_pkg::NCH; c++) begin : g_ch
      diag_seq_pkg::ch_state_t st_reg;
      logic [AW-1:0] t_reg;
      res_t stable_reg, res_reg;
      logic perm_reg, armed_reg, ofs_win_reg, ofs_ok_reg, ofs_res_reg, ac_dis_reg;
      logic [2:0] peaks_reg;
      logic tweet_res_reg;
      logic gpos, gneg;
      assign gpos = diag_seq_pkg::SRC_ON_POS[c] ? gnd_pos[c] : gnd_neg[c];
      assign gneg = diag_seq_pkg::SRC_ON_POS[c] ? gnd_neg[c] : gnd_pos[c];
      // Open load must already count in the sample taken as the pulse starts
      wire res_t now = prio(gpos, gneg, short_vs[c], short_load[c], open_load[c],
                            st_reg == diag_seq_pkg::CH_IDLE || st_reg == diag_seq_pkg::CH_PULSE);

      // Per-channel sequencer
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          st_reg <= diag_seq_pkg::CH_IDLE;
          t_reg <= '0;
          stable_reg <= '0;
          res_reg <= '0;
          perm_reg <= 1'b0;
          armed_reg <= 1'b1;
          done_flag[c] <= 1'b0;
          channel_on[c] <= 1'b0;
        end else begin
          if (host_read) begin
            armed_reg <= 1'b1;
            done_flag[c] <= 1'b0;
          end
          case (st_reg)
            diag_seq_pkg::CH_IDLE: begin
              channel_on[c] <= 1'b0;
              if (standby_exit && diag_enable && armed_reg) begin
                st_reg <= diag_seq_pkg::CH_PULSE;
                t_reg <= '0;
                stable_reg <= now;
                armed_reg <= host_read;
              end else if (standby_off) begin
                st_reg <= diag_seq_pkg::CH_ACTIVE;
              end
            end
            diag_seq_pkg::CH_PULSE: begin
              stable_reg <= stable_reg & now;
              if (tick) begin
                t_reg <= t_reg + 1'b1;
                if (t_reg == ACQ_END) begin
                  // Sampled at the top's end, kept until the next pulse or the end of a diagnostic cycle
                  res_reg <= stable_reg & now;
                  perm_reg <= 1'b0;
                  done_flag[c] <= 1'b1;
                  st_reg <= diag_seq_pkg::CH_ACTIVE;
                end
              end
            end
            diag_seq_pkg::CH_ACTIVE: begin
              channel_on[c] <= 1'b1;
              if (!standby_off) begin
                st_reg <= diag_seq_pkg::CH_IDLE;
              end else if (overload[c]) begin
                channel_on[c] <= 1'b0;
                t_reg <= '0;
                st_reg <= (diag_enable && armed_reg) ? diag_seq_pkg::CH_RECHECK
                                                     : diag_seq_pkg::CH_RESTART;
              end
            end
            diag_seq_pkg::CH_RECHECK: begin
              if (tick) begin
                if (overload[c]) begin
                  st_reg <= diag_seq_pkg::CH_CYCLE;
                  stable_reg <= now;
                  armed_reg <= 1'b0;
                end else begin
                  st_reg <= diag_seq_pkg::CH_ACTIVE;
                end
              end
            end
            diag_seq_pkg::CH_CYCLE: begin
              stable_reg <= stable_reg & now;
              if (tick) begin
                t_reg <= t_reg + 1'b1;
                if (t_reg == CYC_END) begin
                  res_reg <= stable_reg & now;
                  perm_reg <= 1'b1;
                  done_flag[c] <= 1'b1;
                  st_reg <= diag_seq_pkg::CH_RESTART;
                end
              end
            end
            diag_seq_pkg::CH_RESTART: begin
              // Channel stays off; output status polled on each tick
              if (!standby_off) begin
                st_reg <= diag_seq_pkg::CH_IDLE;
              end else if (tick && !overload[c]) begin
                st_reg <= diag_seq_pkg::CH_ACTIVE;
              end
            end
            default: st_reg <= diag_seq_pkg::CH_IDLE;
          endcase
        end
      end
      assign in_pulse[c] = (st_reg == diag_seq_pkg::CH_PULSE);

      // Offset window, closed and reopened by every read
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          ofs_win_reg <= 1'b0;
          ofs_ok_reg <= 1'b0;
          ofs_res_reg <= 1'b0;
        end else if (!offset_enable) begin
          ofs_win_reg <= 1'b0;
          ofs_ok_reg <= 1'b0;
        end else if (host_read || !ofs_win_reg) begin
          ofs_res_reg <= ofs_win_reg && ofs_ok_reg && offset_high[c];
          ofs_win_reg <= 1'b1;
          ofs_ok_reg <= offset_high[c] && !overload[c];
        end else begin
          ofs_ok_reg <= ofs_ok_reg && offset_high[c] && !overload[c];
        end
      end

      // Current peak counter, counts saturate at the decision level
      always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          peaks_reg <= '0;
          ac_dis_reg <= 1'b0;
          tweet_res_reg <= 1'b0;
        end else if (!current_detect_enable) begin
          peaks_reg <= '0;
          ac_dis_reg <= 1'b0;
        end else if (host_read) begin
          tweet_res_reg <= ac_dis_reg ? 1'b0 : (peaks_reg < PEAKS_MIN);
          peaks_reg <= '0;
          ac_dis_reg <= 1'b0;
        end else begin
          if (overload[c]) begin
            ac_dis_reg <= 1'b1;
          end
          if (peak_500ma[c] && peaks_reg < PEAKS_MIN) begin
            peaks_reg <= peaks_reg + 1'b1;
          end
        end
      end
      assign res_pack[c] = res_reg;
      assign perm_v[c] = perm_reg;
      assign tweet_v[c] = tweet_res_reg;
      assign ofs_v[c] = ofs_res_reg;
    end
  endgenerate

  // Read results come from the previous cycle: bytes refresh only on a read
  function automatic logic [7:0] pack(input logic [5:0] r, input logic p, input logic tw,
                                      input logic of, input logic top);
    logic [7:0] b;
    b = '0;
    b[diag_seq_pkg::B_GND] = r[diag_seq_pkg::B_GND];
    b[diag_seq_pkg::B_VS] = r[diag_seq_pkg::B_VS];
    b[diag_seq_pkg::B_OPEN_OFS] = r[diag_seq_pkg::B_OPEN_OFS] || of;
    b[diag_seq_pkg::B_SHORT] = r[diag_seq_pkg::B_SHORT];
    b[diag_seq_pkg::B_PERM] = p;
    b[diag_seq_pkg::B_TWEET] = tw;
    b[diag_seq_pkg::B_OFS_ON] = top;
    return b;
  endfunction

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      diagnostic_byte_one <= '0;
      diag_byte_lr <= '0;
      diag_byte_rf <= '0;
      diag_byte_rr <= '0;
      offset_active <= 1'b0;
    end else begin
      offset_active <= offset_enable;
      if (host_read) begin
        diagnostic_byte_one <= pack(res_pack[0], perm_v[0], tweet_v[0], ofs_v[0], 1'b0);
        diagnostic_byte_one[diag_seq_pkg::B_DONE] <= |done_flag;
        diag_byte_lr <= pack(res_pack[1], perm_v[1], tweet_v[1], ofs_v[1], offset_enable);
        diag_byte_rf <= pack(res_pack[2], perm_v[2], tweet_v[2], ofs_v[2], 1'b0);
        diag_byte_rr <= pack(res_pack[3], perm_v[3], tweet_v[3], ofs_v[3], 1'b0);
      end
    end
  end

  // Fast mute: signal the end of the shortened transition window
  logic [MW-1:0] mute_cnt_reg;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mute_cnt_reg <= '0;
      mute_fast_done <= 1'b0;
    end else if (!fast_mute) begin
      mute_cnt_reg <= '0;
      mute_fast_done <= 1'b0;
    end else if (mute_cnt_reg == MW'(MUTE_CYC)) begin
      mute_fast_done <= 1'b1;
    end else begin
      mute_cnt_reg <= mute_cnt_reg + 1'b1;
    end
  end

  a_hiz_in_pulse: assert property (@(posedge sys_clk) disable iff (!resetn)
    (|in_pulse) |=> outputs_hiz) else $error("outputs driven during test pulse");
  a_hiz_at_exit: assert property (@(posedge sys_clk) disable iff (!resetn)
    (standby_exit && diag_enable) |=> outputs_hiz) else $error("outputs driven at pulse start");
  a_line_thresh: assert property (@(posedge sys_clk) disable iff (!resetn)
    (ldr) |=> line_thresholds) else $error("line thresholds not selected");
  a_bytes_on_read: assert property (@(posedge sys_clk) disable iff (!resetn)
    (!host_read) |=> $stable(diagnostic_byte_one)) else $error("result changed without read");
  a_done_bit: assert property (@(posedge sys_clk) disable iff (!resetn)
    host_read |=> diagnostic_byte_one[diag_seq_pkg::B_DONE] == $past(|done_flag))
    else $error("done bit wrong");
  a_pulse_exit: assert property (@(posedge sys_clk) disable iff (!resetn)
    (standby_exit && diag_enable && g_ch[0].armed_reg) |=> in_pulse[0]) else $error("no pulse");
  a_recheck_go: assert property (@(posedge sys_clk) disable iff (!resetn)
    (g_ch[2].st_reg == diag_seq_pkg::CH_RECHECK && tick && !overload[2] && standby_off)
    |=> g_ch[2].st_reg == diag_seq_pkg::CH_ACTIVE) else $error("recheck failed");
  a_cycle_start: assert property (@(posedge sys_clk) disable iff (!resetn)
    (g_ch[2].st_reg == diag_seq_pkg::CH_RECHECK && tick && overload[2])
    |=> g_ch[2].st_reg == diag_seq_pkg::CH_CYCLE) else $error("cycle not started");
  a_restart_off: assert property (@(posedge sys_clk) disable iff (!resetn)
    (g_ch[2].st_reg == diag_seq_pkg::CH_RESTART) |=> !channel_on[2]) else $error("faulted channel on");
  a_mute_fast: assert property (@(posedge sys_clk) disable iff (!resetn)
    $rose(mute_fast_done) |-> $past(fast_mute, 2)) else $error("fast mute early");
  c_pulse: cover property (@(posedge sys_clk) disable iff (!resetn) $rose(test_pulse));
  c_cycle: cover property (@(posedge sys_clk) disable iff (!resetn)
    g_ch[2].st_reg == diag_seq_pkg::CH_CYCLE);
  c_read: cover property (@(posedge sys_clk) disable iff (!resetn)
    host_read && diagnostic_byte_one[diag_seq_pkg::B_DONE]);
endmodule // diag_seq
`default_nettype wire

// ==== rtl/diag_seq_pkg.sv ====
// Constants shared by the speaker load diagnostic sequencer.
// Assumes a 100 MHz system clock; times are converted to cycle counts here.
// Overview of operation
// - On leaving stand-by with diagnostics requested, run turn-on test for all fault kinds.
// - Turn-on result held until next pulse; new pulse only after a host read.
// - Standby exit plus diag enable together: pulse first, outputs stay high impedance.
// - After bias, go permanent; keep turn-on result until an output short appears.
// - Latch fault status at end of pulse top; acquisition lasts about 100 ms.
// - Ground/supply thresholds fixed; load thresholds line-driver only at 16 dB plus setting.
// - Restart mode: channels independent, faulted one off, checked each 1 ms, restarts.
// - Diagnostic mode: protection triggers 1 ms recheck; no overload means reactivate.
// - Overload still present at recheck starts a 100 ms diagnostic cycle.
// - After cycle channel goes to restart, results stored; next cycle after host read.
// - Flag a DC output offset beyond the detection limit.
// - Offset window opens at last read or enable, closes at read; must persist.
// - Short-circuit protection during test disables offset and current detection.
// - Count current peaks over 500 mA; three or more normal, else open tweeter.
// - With several faults, at least one reported first, others after read-and-removal.
// - Double-fault priority: source ground first, plus supply both; supply, open, sink ground.
// - Source side positive on left-front and right-rear, negative on the other two.
// - Permanent diagnostic never reports open load; only the next turn-on does.
// - A fault is reported only if stable through its whole measurement period.
// - Every read re-arms cycles and returns previous results; changes show on second read.
// - Fast-mute shortens mute below 1.5 ms; host clears the bit soon after.
// - Bit 6 of diagnostic byte one is one once a diagnostic cycle terminated.
`default_nettype none
package diag_seq_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
  localparam int ACQ_MS = 100;
  localparam int CYCLE_MS = 100;
  localparam int FAST_MUTE_US = 1500;
  localparam int FAST_MUTE_CYC = CLK_HZ / 1_000_000 * FAST_MUTE_US - 1;
  localparam int NORMAL_MUTE_MS = 20;
  localparam int MIN_PEAKS = 3;
  localparam int NCH = 4;
  // Result byte layout per channel
  localparam int B_GND = 0;
  localparam int B_VS = 1;
  localparam int B_OPEN_OFS = 2;
  localparam int B_SHORT = 3;
  localparam int B_PERM = 4;
  localparam int B_TWEET = 5;
  localparam int B_DONE = 6;
  localparam int B_OFS_ON = 7;
  // Channel index 0 LF, 1 LR, 2 RF, 3 RR; one marks source on positive output
  localparam logic [3:0] SRC_ON_POS = 4'h9;
  typedef enum logic [2:0] {
    CH_IDLE = 3'b000,
    CH_PULSE = 3'b001,
    CH_ACTIVE = 3'b010,
    CH_RECHECK = 3'b011,
    CH_CYCLE = 3'b100,
    CH_RESTART = 3'b101
  } ch_state_t;
endpackage
`default_nettype wire

// ==== verif/diag_seq_tb_top.sv ====
// Self-checking bench for the load diagnostic sequencer.
// Assumes shortened timebase parameters; fault levels come from this bench.
`default_nettype none
module diag_seq_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 10;
  localparam int ACQ = 4;
  localparam int CYC = 4;
  localparam int MUTE = 20;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic diag_enable, offset_enable, standby_off, line_driver_diag, current_detect_enable, fast_mute, host_read;
  logic [1:0] gain_16db;
  logic [3:0] gnd_pos = 4'h0, gnd_neg = 4'h0, short_vs = 4'h0, short_load = 4'h0;
  logic [3:0] open_load = 4'h0, overload = 4'h0, offset_high = 4'h0, peak_500ma = 4'h0;
  logic [3:0] channel_on;
  logic outputs_hiz, test_pulse, line_thresholds, offset_active, mute_fast_done;
  logic [7:0] diagnostic_byte_one, diag_byte_lr, diag_byte_rf, diag_byte_rr;
  logic [7:0] b1, blr, brf, brr;
  int error_cnt = 0;
  int n_checks = 0;
  int n;
  always #5 sys_clk = ~sys_clk;
  diag_seq #(.TICK_CYC(TICK), .ACQ_TICKS(ACQ), .CYCLE_TICKS(CYC), .MUTE_CYC(MUTE)) i_diag_seq (
    .sys_clk(sys_clk), .resetn(resetn), .diag_enable(diag_enable), .offset_enable(offset_enable),
    .gain_16db(gain_16db), .standby_off(standby_off), .line_driver_diag(line_driver_diag),
    .current_detect_enable(current_detect_enable), .fast_mute(fast_mute), .host_read(host_read),
    .gnd_pos(gnd_pos), .gnd_neg(gnd_neg), .short_vs(short_vs), .short_load(short_load),
    .open_load(open_load), .overload(overload), .offset_high(offset_high), .peak_500ma(peak_500ma),
    .channel_on(channel_on), .outputs_hiz(outputs_hiz), .test_pulse(test_pulse),
    .line_thresholds(line_thresholds), .diagnostic_byte_one(diagnostic_byte_one),
    .diag_byte_lr(diag_byte_lr), .diag_byte_rf(diag_byte_rf), .diag_byte_rr(diag_byte_rr),
    .offset_active(offset_active), .mute_fast_done(mute_fast_done));
  host_model i_host_model (
    .sys_clk(sys_clk), .diag_enable(diag_enable), .offset_enable(offset_enable), .gain_16db(gain_16db),
    .standby_off(standby_off), .line_driver_diag(line_driver_diag),
    .current_detect_enable(current_detect_enable), .fast_mute(fast_mute), .host_read(host_read),
    .diagnostic_byte_one(diagnostic_byte_one), .diag_byte_lr(diag_byte_lr),
    .diag_byte_rf(diag_byte_rf), .diag_byte_rr(diag_byte_rr));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic wait_cyc(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  task automatic rd();
    i_host_model.read_diag(b1, blr, brf, brr);
  endtask
  // Tone of four sine cycles; each channel gets its own count of strong peaks
  task automatic tone(input int c0, input int c1, input int c2, input int c3);
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      peak_500ma <= {i < c3, i < c2, i < c1, i < c0};
      @(posedge sys_clk);
      peak_500ma <= 4'h0;
      repeat (3) @(posedge sys_clk);
    end
  endtask
  initial begin
    repeat (5) @(posedge sys_clk);
    #1;
    check("hiz in reset", {7'h00, outputs_hiz}, 8'h01);
    check("on in reset", {4'h0, channel_on}, 8'h00);
    check("byte1 in reset", diagnostic_byte_one, 8'h00);
    @(posedge sys_clk);
    resetn <= 1'b1;
    wait_cyc(2);
    // LF: source ground with supply short; LR: sink ground with open load; RF: shorted load
    @(posedge sys_clk);
    gnd_pos <= 4'h3;
    short_vs <= 4'h1;
    open_load <= 4'h2;
    short_load <= 4'h4;
    i_host_model.write_ib(1'b1, 1'b0, 2'b00, 1'b1, 1'b0, 1'b0, 1'b0);
    wait_cyc(1);
    check("stage hiz at exit", {7'h00, outputs_hiz}, 8'h01);
    wait_cyc(2);
    check("pulse running", {7'h00, test_pulse}, 8'h01);
    check("stage hiz in pulse", {7'h00, outputs_hiz}, 8'h01);
    check("stage off in pulse", {4'h0, channel_on}, 8'h00);
    n = 0;
    while (test_pulse !== 1'b0) begin
      n++;
      if (n > 500) begin
        error_cnt++;
        complete_run();
      end
      wait_cyc(1);
    end
    check("acq length", {7'h00, 1'(n >= ACQ * TICK - TICK - 3 && n <= ACQ * TICK + TICK)}, 8'h01);
    wait_cyc(3);
    check("biased after pulse", {7'h00, outputs_hiz}, 8'h00);
    {gnd_pos, short_vs, open_load, short_load} <= 16'h0000;
    wait_cyc(5);
    rd();
    check("byte1 turn-on", b1, 8'h43);
    check("lr turn-on", blr, 8'h04);
    check("rf turn-on", brf, 8'h08);
    check("rr turn-on", brr, 8'h00);
    rd();
    check("done after reread", {7'h00, b1[6]}, 8'h00);
    for (int k = 0; k < 3; k++) begin
      i_host_model.write_ib(1'b1, 1'b0, (k == 1) ? 2'b00 : 2'b11, 1'b1, k != 2, 1'b0, 1'b0);
      wait_cyc(3);
      check("line thresholds", {7'h00, line_thresholds}, {7'h00, 1'(k == 0)});
    end
    // Brief overload clears before the recheck
    @(posedge sys_clk);
    overload <= 4'h4;
    @(posedge sys_clk);
    overload <= 4'h0;
    wait_cyc((CYC + 3) * TICK);
    check("glitch recovered", {4'h0, channel_on}, 8'h0f);
    rd();
    check("no cycle on glitch", {7'h00, b1[6]}, 8'h00);
    @(posedge sys_clk);
    overload <= 4'h4;
    short_load <= 4'h4;
    open_load <= 4'h4;
    wait_cyc(3);
    check("rf shut alone", {4'h0, channel_on}, 8'h0b);
    wait_cyc((CYC + 3) * TICK);
    check("rf still off", {7'h00, channel_on[2]}, 8'h00);
    rd();
    check("perm done", {7'h00, b1[6]}, 8'h01);
    check("rf perm", brf, 8'h18);
    overload <= 4'h0;
    wait_cyc(3 * TICK);
    check("rf restarted", {7'h00, channel_on[2]}, 8'h01);
    short_load <= 4'h0;
    open_load <= 4'h0;
    // Offset on RR; second window broken by a dip
    @(posedge sys_clk);
    offset_high <= 4'h8;
    i_host_model.write_ib(1'b1, 1'b1, 2'b00, 1'b1, 1'b0, 1'b0, 1'b0);
    wait_cyc(20);
    check("offset active", {7'h00, offset_active}, 8'h01);
    rd();
    // A window's verdict is shown by the read after the one that closes it
    check("rr offset first read", {7'h00, brr[2]}, 8'h00);
    check("lr offset enabled", {7'h00, blr[7]}, 8'h01);
    offset_high <= 4'h0;
    wait_cyc(3);
    offset_high <= 4'h8;
    wait_cyc(20);
    rd();
    check("rr offset", {7'h00, brr[2]}, 8'h01);
    offset_high <= 4'h0;
    wait_cyc(3);
    rd();
    check("rr offset dipped", {7'h00, brr[2]}, 8'h00);
    i_host_model.write_ib(1'b1, 1'b0, 2'b00, 1'b1, 1'b0, 1'b1, 1'b0);
    tone(3, 2, 0, 4);
    rd();
    check("tweeter before", {4'h0, brr[5], brf[5], blr[5], b1[5]}, 8'h00);
    rd();
    check("lf tweeter", {7'h00, b1[5]}, 8'h00);
    check("lr tweeter", {7'h00, blr[5]}, 8'h01);
    check("rf tweeter", {7'h00, brf[5]}, 8'h01);
    check("rr tweeter", {7'h00, brr[5]}, 8'h00);
    i_host_model.write_ib(1'b1, 1'b0, 2'b00, 1'b1, 1'b0, 1'b0, 1'b1);
    wait_cyc(10);
    check("fast mute early", {7'h00, mute_fast_done}, 8'h00);
    wait_cyc(MUTE);
    check("fast mute done", {7'h00, mute_fast_done}, 8'h01);
    i_host_model.write_ib(1'b1, 1'b0, 2'b00, 1'b1, 1'b0, 1'b0, 1'b0);
    wait_cyc(2);
    check("fast mute cleared", {7'h00, mute_fast_done}, 8'h00);
    complete_run();
  end
endmodule // diag_seq_tb_top
`default_nettype wire

// ==== verif/host_model.sv ====
// Host controller model: drives the instruction bits and the read strobe.
// Assumes the sequencer samples every level on the rising edge of sys_clk.
`default_nettype none
module host_model (
  input wire logic sys_clk,
  output logic diag_enable,
  output logic offset_enable,
  output logic [1:0] gain_16db,
  output logic standby_off,
  output logic line_driver_diag,
  output logic current_detect_enable,
  output logic fast_mute,
  output logic host_read,
  input wire logic [7:0] diagnostic_byte_one,
  input wire logic [7:0] diag_byte_lr,
  input wire logic [7:0] diag_byte_rf,
  input wire logic [7:0] diag_byte_rr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {diag_enable, offset_enable, gain_16db, standby_off} = 5'h00;
    {line_driver_diag, current_detect_enable, fast_mute, host_read} = 4'h0;
  end
  // All bits change at one edge, so a stand-by exit and enable form one write
  task automatic write_ib(input logic d, input logic o, input logic [1:0] g, input logic s,
                          input logic ld, input logic cd, input logic fm);
    @(posedge sys_clk);
    diag_enable <= d;
    offset_enable <= o;
    gain_16db <= g;
    standby_off <= s;
    line_driver_diag <= ld;
    current_detect_enable <= cd;
    fast_mute <= fm;
  endtask
  // One-cycle strobe per completed read; bytes are taken once that edge landed
  task automatic read_diag(output logic [7:0] b1, output logic [7:0] blr, output logic [7:0] brf,
                           output logic [7:0] brr);
    @(posedge sys_clk);
    host_read <= 1'b1;
    @(posedge sys_clk);
    host_read <= 1'b0;
    #1;
    b1 = diagnostic_byte_one;
    blr = diag_byte_lr;
    brf = diag_byte_rf;
    brr = diag_byte_rr;
  endtask
endmodule // host_model
`default_nettype wire
